// ===== common/hspp_consts.vh
// Constants for the hub strap latch and port power pin block
`ifndef HSPP_CONSTS_VH
`define HSPP_CONSTS_VH
`define HSPP_NPORTS         4
`define HSPP_STRAP_RST      1'b1
`define HSPP_CHG_RST        4'h0
`define HSPP_ADDR_BIT1      1
`define HSPP_MODE_I2C       1'b1
`define HSPP_MODE_SMBUS     1'b0
`define HSPP_ACP_ALL        2'h0
`define HSPP_ACP_HIGH_ONLY  2'h1
`define HSPP_ACP_OFF        2'h2
`endif

// ===== logic/hspp_strap_pins.v
// Strap latching and shared pin muxing for downstream port power and serial mode
`timescale 1ns/1ps
`include "hspp_consts.vh"
// ****************************************
// Notes for integrators
// ****************************************
// Timing after reset release:
//   edge 1 captures every strap level once
//   edge 2 raises the run flag and turns the power pins to outputs, the status pins only with their enable high
//   edge 3 shows the first registered fault values; power is registered from edge 2
// Faults seen before edge 3 are ignored on purpose: the strap
// pins are still being read as inputs and must not be driven from inside.
// Limitations:
//   The strap levels are taken as settled at the release of reset; the board
//   pull resistors must have charged the pins by then, there is no filter.
//   Charge straps need full power management strapped on; that is the
//   board's duty and is not checked here.
//   Ganged power uses one shared request and one shared fault flag, so a
//   fault on any pin sets every port's overcurrent flag together.
//
module hspp_strap_pins (
  // Clock and reset
  input  wire       core_clk_in,
  input  wire       rst_n_in,
  // Port power switch pins, shared with charge straps
  input  wire [3:0] port_power_switch_ctl_in,
  output reg  [3:0] port_power_switch_ctl_out,
  output wire [3:0] port_power_switch_ctl_oe_n_out,
  // Overcurrent inputs, active low
  input  wire [3:0] supply_fault_n_in,
  // Shared strap and status pins
  input  wire       smbus_select_n_in,
  output reg        smbus_select_n_out,
  output wire       smbus_select_n_oe_n_out,
  input  wire       full_power_mgmt_n_in,
  output reg        full_power_mgmt_n_out,
  output wire       full_power_mgmt_n_oe_n_out,
  input  wire       power_ctl_polarity_in,
  input  wire       gang_power_strap_in,
  input  wire       auto_charge_enable_n_in,
  // Hub core side
  input  wire [3:0] port_power_req_in,
  input  wire       status_output_enable_in,
  input  wire       ss_suspend_in,
  input  wire       superspeed_link_flag_in,
  // Latched configuration and status
  output wire [3:0] charge_capable_out,
  output wire       i2c_master_mode_out,
  output wire       smbus_slave_mode_out,
  output wire       smbus_addr_bit1_strap_out,
  output wire       power_switching_en_out,
  output wire       ganged_mode_out,
  output wire       auto_charge_en_out,
  output wire [1:0] charge_profile_sel_out,
  output reg  [3:0] port_overcurrent_out
);

  // ****************************************
  // Strap capture
  // ****************************************
  reg       cap_done_q;
  reg [3:0] chg_q;
  reg       smbus_n_q;
  reg       fpm_n_q;
  reg       pol_q;
  reg       gang_q;
  reg       auto_n_q;
  reg       run_q;

  // Captured on the first edge after release, never again; async reset loads constants only
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_done_q <= 1'b0;
      chg_q      <= `HSPP_CHG_RST;
      smbus_n_q  <= `HSPP_STRAP_RST;
      fpm_n_q    <= `HSPP_STRAP_RST;
      pol_q      <= `HSPP_STRAP_RST;
      gang_q     <= 1'b0;
      auto_n_q   <= `HSPP_STRAP_RST;
    end else if (!cap_done_q) begin
      cap_done_q <= 1'b1;
      chg_q      <= port_power_switch_ctl_in;
      smbus_n_q  <= smbus_select_n_in;
      fpm_n_q    <= full_power_mgmt_n_in;
      pol_q      <= power_ctl_polarity_in;
      gang_q     <= gang_power_strap_in;
      auto_n_q   <= auto_charge_enable_n_in;
    end
  end

  // Pins turn to outputs one cycle after capture so the strap level is never self-driven
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      run_q <= 1'b0;
    else
      run_q <= cap_done_q;
  end

  // ****************************************
  // Configuration decode
  // ****************************************
  assign charge_capable_out        = chg_q;
  assign i2c_master_mode_out       = run_q & (smbus_n_q == `HSPP_MODE_I2C);
  assign smbus_slave_mode_out      = run_q & (smbus_n_q == `HSPP_MODE_SMBUS);
  assign smbus_addr_bit1_strap_out = ~smbus_n_q & fpm_n_q;
  assign power_switching_en_out    = ~fpm_n_q;
  assign ganged_mode_out           = ~fpm_n_q & gang_q;
  assign auto_charge_en_out        = ~auto_n_q;
  // All DIVIDER_CHARGE_PROFILE modes bit shares the full power strap level
  assign charge_profile_sel_out    = auto_n_q ? `HSPP_ACP_OFF :
                                     (fpm_n_q ? `HSPP_ACP_HIGH_ONLY
                                              : `HSPP_ACP_ALL);

  // ****************************************
  // Overcurrent and power switch outputs
  // ****************************************
  // Any single fault pin may carry the shared ganged flag; unused pins idle
  // high through their pull-ups, so a plain AND of the levels is enough
  wire       any_fault  = ~&supply_fault_n_in;
  // Any request powers every switch when the ports are ganged
  wire       any_req    = |port_power_req_in;
  // Faults only count once the pins run and power switching is strapped on
  wire       fault_gate = run_q & ~fpm_n_q;
  wire [3:0] oc_d;
  wire [3:0] pwr_d;

  // Per-port next values; each port sees its own pins or the shared terms
  genvar gi;
  generate
    for (gi = 0; gi < `HSPP_NPORTS; gi = gi + 1) begin : g_port
      // Active low fault pin turned into an active high flag
      wire fault_raw = ~supply_fault_n_in[gi];
      // Ganged mode takes the shared fault flag instead
      wire fault_sel = gang_q ? any_fault : fault_raw;
      // Requested power, ganged or individual
      wire pwr_on    = gang_q ? any_req : port_power_req_in[gi];
      assign oc_d[gi]  = fault_gate & fault_sel;
      // Polarity strap inverts the pin for active low switches
      assign pwr_d[gi] = (pwr_on & ~fpm_n_q) ^ ~pol_q;
    end
  endgenerate

  // Registered so the fault flags never glitch with the pin levels
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      port_overcurrent_out <= 4'h0;
    else
      port_overcurrent_out <= oc_d;
  end

  // Switch enables come from flip-flops; power stays off while switching is strapped off
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      port_power_switch_ctl_out <= 4'h0;
    else
      port_power_switch_ctl_out <= pwr_d;
  end

  // Power pins are read as charge straps until the run flag rises
  assign port_power_switch_ctl_oe_n_out = {4{~run_q}};

  // ****************************************
  // Status outputs on shared strap pins
  // ****************************************
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smbus_select_n_out    <= 1'b0;
      full_power_mgmt_n_out <= 1'b0;
    end else begin
      smbus_select_n_out    <= ss_suspend_in;
      full_power_mgmt_n_out <= superspeed_link_flag_in;
    end
  end
  // Status drive needs both the run flag and the enable; with the enable low
  // the pins stay inputs so the board pulls keep their strap levels visible
  wire sts_drive = run_q & status_output_enable_in;
  assign smbus_select_n_oe_n_out    = ~sts_drive;
  assign full_power_mgmt_n_oe_n_out = ~sts_drive;

endmodule // hspp_strap_pins

// ===== tb/hspp_strap_pins_tb.sv
// Testbench for strap capture, power pins and status pins
`timescale 1ns/1ps
`include "hspp_consts.vh"
module hspp_strap_pins_tb;
  reg clk = 0, rst_n = 0, en = 0, sus = 0, lnk = 0;
  reg [8:0] st = 9'h01a;
  reg [3:0] req = 4'h0, trip = 4'h0;
  wire [3:0] chg, pc_o, pc_oe, pwr_pin, fault_n, on, cap, oc;
  wire smb, fpm, pol, gang, auto_n, smb_o, smb_oe, fpm_o, fpm_oe, i2c, slv, a1, pse, gng, ace;
  wire [1:0] prof;
  integer err_count = 0, n_checks = 0, cyc = 0;
  assign {chg, smb, fpm, pol, gang, auto_n} = st;
  // Undriven pins show the board strap
  assign pwr_pin = (pc_oe & chg) | (~pc_oe & pc_o);
  wire smb_pin = smb_oe ? smb : smb_o;
  wire fpm_pin = fpm_oe ? fpm : fpm_o;
  hspp_switch_model sw (.pin_in(pwr_pin), .oe_n_in(pc_oe), .trip_in(trip), .pol_in(pol), .on_out(on), .fault_n_out(fault_n));
  hspp_strap_pins dut (.core_clk_in(clk), .rst_n_in(rst_n), .port_power_switch_ctl_in(pwr_pin),
    .port_power_switch_ctl_out(pc_o), .port_power_switch_ctl_oe_n_out(pc_oe), .supply_fault_n_in(fault_n),
    .smbus_select_n_in(smb_pin), .smbus_select_n_out(smb_o), .smbus_select_n_oe_n_out(smb_oe),
    .full_power_mgmt_n_in(fpm_pin), .full_power_mgmt_n_out(fpm_o), .full_power_mgmt_n_oe_n_out(fpm_oe),
    .power_ctl_polarity_in(pol), .gang_power_strap_in(gang), .auto_charge_enable_n_in(auto_n),
    .port_power_req_in(req), .status_output_enable_in(en), .ss_suspend_in(sus), .superspeed_link_flag_in(lnk),
    .charge_capable_out(cap), .i2c_master_mode_out(i2c), .smbus_slave_mode_out(slv), .smbus_addr_bit1_strap_out(a1),
    .power_switching_en_out(pse), .ganged_mode_out(gng), .auto_charge_en_out(ace), .charge_profile_sel_out(prof),
    .port_overcurrent_out(oc));
  initial forever #5 clk = ~clk;
  task chk(input [8*5:1] nm, input [7:0] s, input [7:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin err_count = err_count + 1; $display("Error %0s expected %h seen %h", nm, e, s); end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Reset with straps s, then flip straps and run traffic; status enable is set after capture and stays set through later resets
  task boot(input [8:0] s);
    begin
      @(posedge clk); st <= s; rst_n <= 1'b0; sus <= 1'b1; lnk <= 1'b0; req <= 4'h0; trip <= 4'h0;
      repeat (10) @(posedge clk);
      chk("oe", {pc_oe, smb_oe, fpm_oe}, 8'h3f);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk); #1;
      chk("cap", cap, s[8:5]);
      chk("mode", {i2c, slv, a1}, {s[4], ~s[4], ~s[4] & s[3]});
      chk("pwr", {pse, gng, ace}, {~s[3], ~s[3] & s[1], ~s[0]});
      chk("prof", prof, s[0] ? `HSPP_ACP_OFF : s[3] ? `HSPP_ACP_HIGH_ONLY : `HSPP_ACP_ALL);
      @(posedge clk); st <= s ^ 9'h1fb; req <= 4'h9; trip <= 4'h6; en <= 1'b1;
      repeat (2) @(posedge clk); #1;
      chk("hold", {cap, pse, gng, ace, i2c}, {s[8:5], ~s[3], ~s[3] & s[1], ~s[0], s[4]});
      chk("on", on, {4{~s[3]}} & ((s[1] & ~s[3]) ? 4'hf : 4'h9));
      chk("oc", oc, {4{~s[3]}} & ((s[1] & ~s[3]) ? 4'hf : 4'h6));
      chk("sts", {smb_pin, fpm_pin, smb_oe, fpm_oe}, 8'h08);
      $display("test %h done", s);
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 500) begin err_count = err_count + 1; results; end
  end
  // Charge straps only with full power management enabled on the board
  initial begin
    boot(9'h180);
    boot(9'h01c);
    boot(9'h067);
    boot(9'h009);
    results;
  end
endmodule // hspp_strap_pins_tb

// ===== tb/hspp_strap_sva.sv
// Checker for strap capture and shared pin behaviour
`timescale 1ns/1ps
`include "hspp_consts.vh"
module hspp_strap_sva (
  input wire core_clk_in, rst_n_in, power_ctl_polarity_in, status_output_enable_in, ss_suspend_in,
  input wire superspeed_link_flag_in, smbus_select_n_out, smbus_select_n_oe_n_out, full_power_mgmt_n_out,
  input wire full_power_mgmt_n_oe_n_out, i2c_master_mode_out, smbus_slave_mode_out, smbus_addr_bit1_strap_out,
  input wire power_switching_en_out, ganged_mode_out, auto_charge_en_out,
  input wire [1:0] charge_profile_sel_out,
  input wire [3:0] port_power_req_in, port_power_switch_ctl_out, port_power_switch_ctl_oe_n_out,
  input wire [3:0] supply_fault_n_in, charge_capable_out, port_overcurrent_out
);
  // Phase 0 is the capture edge, 2 is running; polarity kept here since no port shows it
  reg [1:0] ph_q;
  reg       pol_q;
  always @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) begin ph_q <= 2'h0; pol_q <= 1'b1; end
    else begin ph_q <= (ph_q == 2'h2) ? ph_q : ph_q + 2'h1; pol_q <= (ph_q == 2'h0) ? power_ctl_polarity_in : pol_q; end
  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_run; ph_q == 2'h2 ##1 ph_q == 2'h2; endsequence
  a_pins_undriven: assert property (ph_q != 2'h2 |->
    &{port_power_switch_ctl_oe_n_out, smbus_select_n_oe_n_out, full_power_mgmt_n_oe_n_out}) else $error("early drive");
  a_power_driven: assert property (ph_q == 2'h2 |-> port_power_switch_ctl_oe_n_out == 4'h0) else $error("no drive");
  a_status_gate: assert property (ph_q == 2'h2 |->
    {smbus_select_n_oe_n_out, full_power_mgmt_n_oe_n_out} == {2{!status_output_enable_in}}) else $error("status oe");
  a_power_level: assert property (s_run |-> port_power_switch_ctl_out ==
    $past(((ganged_mode_out ? {4{|port_power_req_in}} : port_power_req_in)
      & {4{power_switching_en_out}}) ^ {4{~pol_q}})) else $error("power level");
  a_fault_gang: assert property (s_run ##0 ganged_mode_out |-> port_overcurrent_out ==
    {4{$past(~&supply_fault_n_in)}}) else $error("gang fault");
  a_status_copy: assert property (s_run |-> {smbus_select_n_out, full_power_mgmt_n_out} ==
    $past({ss_suspend_in, superspeed_link_flag_in})) else $error("status level");
  a_config_held: assert property (s_run |-> $stable({charge_capable_out, power_switching_en_out,
    ganged_mode_out, auto_charge_en_out, i2c_master_mode_out})) else $error("config moved");
  a_fault_map: assert property (s_run ##0 !ganged_mode_out |-> port_overcurrent_out ==
    $past(~supply_fault_n_in & {4{power_switching_en_out}})) else $error("fault map");
  a_profile_sel: assert property (ph_q == 2'h2 |-> charge_profile_sel_out == (!auto_charge_en_out ?
    `HSPP_ACP_OFF : power_switching_en_out ? `HSPP_ACP_ALL : `HSPP_ACP_HIGH_ONLY)) else $error("profile");
  a_serial_mode: assert property (ph_q == 2'h2 |-> i2c_master_mode_out != smbus_slave_mode_out &&
    smbus_addr_bit1_strap_out == (smbus_slave_mode_out & !power_switching_en_out)) else $error("serial mode");
endmodule // hspp_strap_sva
bind hspp_strap_pins hspp_strap_sva u_sva (.*);

// ===== tb/hspp_switch_model.sv
// Downstream power switch model with driven active low fault flag
`timescale 1ns/1ps
module hspp_switch_model (
  input  wire [3:0] pin_in, oe_n_in, trip_in,
  input  wire       pol_in,
  output wire [3:0] on_out, fault_n_out
);
  // Undriven pin leaves the switch off whatever the strap level
  assign on_out = ~oe_n_in & (pin_in ^ {4{~pol_in}});
  assign fault_n_out = ~trip_in;
endmodule // hspp_switch_model
